/* ccsg_clock_net.v */
// clock network select and gate: control blocks, fan-out, register bus
// Functional notes
// - own control block per global, regional, pin
// - global select from configuration or user logic
// - dynamic switching chooses between exactly two candidates
// - static global selection may pick any input
// - corner PLL outputs never dynamically selectable
// - regional and pin selects are configuration only
// - dynamic selects obeyed only in user mode
// - user logic enables each net synchronously
// - enable acts on net, PLL keeps running
// - powered-down net delivers no clock edges
// - static disable; unused nets default off
// - pin element muxes user signal or clock
// - eight regional nets per quadrant
// - 24 resources per quadrant feed row buses
// - block picks three of six row clocks
// - I/O region takes eight of 24 resources
// - one source drives two adjacent regional lines
// - dual-regional direction limits; corner PLLs excluded
// - only top/bottom complement pins reach regional selects
// - dynamic global only true pins, fast and enhanced PLL outputs
`timescale 1ns/1ps
`include "ccsg_consts.vh"
module ccsg_clock_net #(
  parameter NPIN = 8,
  parameter AW = 12
) (
  input wire clock, // 40 MHz system clock
  input wire rst_n, // sync reset, low
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [AW-1:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte enables
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire [15:0] trueClockInput, // true clock pins
  input wire [15:0] complementClockInput, // complement clock pins
  input wire [7:0] fastPllClock, // fast PLL outputs
  input wire [3:0] enhancedPllClock, // enhanced PLL outputs
  input wire [3:0] cornerPllClock, // corner PLL outputs
  input wire [15:0] internalGlobalDrive, // fabric drive, globals
  input wire [31:0] internalRegionalDrive, // fabric drive, regionals
  input wire userMode, // device in user mode
  input wire [31:0] globalDynSelect, // 2 bits per global net
  input wire [15:0] globalDynEnable, // per global net
  input wire [31:0] regionalDynEnable, // per regional net
  input wire [NPIN-1:0] pinDynEnable, // per PLL output pin
  input wire [NPIN-1:0] pinUserSignal, // ordinary pin data
  output wire [15:0] globalClockNet, // global nets
  output wire [31:0] regionalClockNet, // regional nets
  output reg [NPIN-1:0] pllOutPin, // PLL output pins
  output wire [23:0] rowClock, // 6 row clocks per quadrant
  output wire [11:0] labClock, // 3 block clocks per quadrant
  output wire [31:0] ioClock // 8 I/O clocks per quadrant
);
  // ----------------------------------------
  // configuration storage
  // ----------------------------------------
  localparam NG = `CCSG_N_GLOBAL;
  localparam NR = `CCSG_N_QUAD * `CCSG_N_RPQ;
  localparam NQW = `CCSG_N_QUAD * 4;
  localparam IR = NG;
  localparam IP = NG + NR;
  localparam IQ = NG + NR + NPIN;
  localparam NCFG = IQ + NQW;
  localparam SW = `CCSG_SEL_W;

  reg [31:0] cfg [0:NCFG-1];
  wire [15:0] globalActive;
  wire [31:0] regionalActive;
  wire [15:0] globalChoice;
  wire [NPIN-1:0] pinActive;
  wire [NPIN-1:0] pinCtrlOut;

  wire [15:0] pllVec = {cornerPllClock, enhancedPllClock, fastPllClock};

  // address decode: {hit, index}
  function [7:0] cfgIndex;
    input [AW-1:0] a;
    reg [AW-1:0] w;
    begin
      cfgIndex = 8'h00;
      if (a >= `CCSG_OFS_GLOBAL && a < `CCSG_OFS_GLOBAL + 4 * NG) begin
        w = a - `CCSG_OFS_GLOBAL;
        cfgIndex = {1'b1, w[8:2]};
      end else if (a >= `CCSG_OFS_REGION && a < `CCSG_OFS_REGION + 4 * NR) begin
        w = a - `CCSG_OFS_REGION;
        cfgIndex = {1'b1, w[8:2] + 7'd16};
      end else if (a >= `CCSG_OFS_PIN && a < `CCSG_OFS_PIN + 4 * NPIN) begin
        w = a - `CCSG_OFS_PIN;
        cfgIndex = {1'b1, w[8:2] + 7'd48};
      end else if (a >= `CCSG_OFS_QUAD && a < `CCSG_OFS_QUAD + 4 * NQW) begin
        w = a - `CCSG_OFS_QUAD;
        cfgIndex = {1'b1, w[8:2] + IQ[6:0]};
      end
    end
  endfunction

  function [31:0] byteMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer b;
    begin
      byteMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) byteMerge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // dual-regional source eligibility by direction
  function dualOk;
    input [SW-1:0] s;
    input vert;
    begin
      if (s == `CCSG_SRC_INTERNAL) dualOk = 1'b1;
      else if (vert) dualOk = (s < `CCSG_PIN_TB) ||
        (s >= `CCSG_SRC_FAST && s < `CCSG_SRC_ENH);
      else dualOk = (s >= `CCSG_PIN_TB && s < `CCSG_SRC_COMPL) ||
        (s >= `CCSG_SRC_ENH && s < `CCSG_SRC_CORNER);
    end
  endfunction

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  wire [7:0] hitIdx = cfgIndex(wb_adr_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  reg [31:0] next_dat;

  always @* begin
    next_dat = 32'h00000000;
    if (hitIdx[7]) begin
      next_dat = cfg[hitIdx[6:0]];
    end else begin
      case (wb_adr_i)
        `CCSG_OFS_ST_GLOBAL: next_dat = {16'h0000, globalActive};
        `CCSG_OFS_ST_REGION: next_dat = regionalActive;
        `CCSG_OFS_ST_CHOICE: next_dat = {16'h0000, globalChoice};
        `CCSG_OFS_ST_PIN: next_dat = {{(32 - NPIN){1'b0}}, pinActive};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  integer n;
  always @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      for (n = 0; n < NCFG; n = n + 1) begin
        cfg[n] <= `CCSG_CFG_RST;
      end
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) wb_dat_o <= next_dat;
      if (req && wb_we_i && hitIdx[7]) begin
        cfg[hitIdx[6:0]] <= byteMerge(cfg[hitIdx[6:0]], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ----------------------------------------
  // global control blocks
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : gGlob
      ccsg_ctrl_block #(.DYN(1)) uCtl (
        .clock(clock),
        .rst_n(rst_n),
        .srcVec({internalGlobalDrive[g], pllVec, complementClockInput,
          trueClockInput}),
        .staticSel(cfg[g][`CCSG_F_SEL +: SW]),
        .altSel(cfg[g][`CCSG_F_ALT +: SW]),
        .dynMode(cfg[g][`CCSG_F_DYN]),
        .dynSel(globalDynSelect[2*g +: 2]),
        .userMode(userMode),
        .staticEn(cfg[g][`CCSG_F_EN]),
        .dynEn(globalDynEnable[g]),
        .netOut(globalClockNet[g]),
        .netActive(globalActive[g]),
        .choiceB(globalChoice[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // regional control blocks
  // ----------------------------------------
  // quadrants 0 1 top, 2 3 bottom: horizontal partner q^1, vertical q^2
  genvar r;
  generate
    for (r = 0; r < NR; r = r + 1) begin : gReg
      localparam Q = r / `CCSG_N_RPQ;
      localparam L = r % `CCSG_N_RPQ;
      localparam QH = Q ^ 1;
      localparam QV = Q ^ 2;
      localparam PH = QH * `CCSG_N_RPQ + L;
      localparam PV = QV * `CCSG_N_RPQ + L;
      wire [31:0] own = cfg[IR + r];
      wire vert = own[`CCSG_F_VERT];
      wire [31:0] mate = vert ? cfg[IR + PV] : cfg[IR + PH];
      wire [SW-1:0] mateSel = mate[`CCSG_F_SEL +: SW];
      wire follow = own[`CCSG_F_DUAL] && dualOk(mateSel, vert);
      wire [SW-1:0] useSel = follow ? mateSel : own[`CCSG_F_SEL +: SW];
      wire intDrv = !follow ? internalRegionalDrive[r] :
        (vert ? internalRegionalDrive[PV] : internalRegionalDrive[PH]);
      ccsg_ctrl_block #(.DYN(0)) uCtl (
        .clock(clock),
        .rst_n(rst_n),
        .srcVec({intDrv, pllVec, complementClockInput & `CCSG_COMPL_TB_MASK,
          trueClockInput}),
        .staticSel(useSel),
        .altSel(useSel),
        .dynMode(1'b0),
        .dynSel(`CCSG_DSEL_A),
        .userMode(userMode),
        .staticEn(own[`CCSG_F_EN]),
        .dynEn(regionalDynEnable[r]),
        .netOut(regionalClockNet[r]),
        .netActive(regionalActive[r]),
        .choiceB()
      );
    end
  endgenerate

  // ----------------------------------------
  // PLL output pin control blocks
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : gPin
      wire [31:0] pc = cfg[IP + p];
      ccsg_ctrl_block #(.DYN(0)) uCtl (
        .clock(clock),
        .rst_n(rst_n),
        .srcVec({1'b0, pllVec, complementClockInput, trueClockInput}),
        .staticSel(pc[`CCSG_F_SEL +: SW]),
        .altSel(pc[`CCSG_F_SEL +: SW]),
        .dynMode(1'b0),
        .dynSel(`CCSG_DSEL_A),
        .userMode(userMode),
        .staticEn(pc[`CCSG_F_EN]),
        .dynEn(pinDynEnable[p]),
        .netOut(pinCtrlOut[p]),
        .netActive(pinActive[p]),
        .choiceB()
      );
      // dual-purpose pin: clock path or ordinary data
      always @(posedge clock) begin
        if (!rst_n) pllOutPin[p] <= 1'b0;
        else pllOutPin[p] <= pc[`CCSG_F_PINMUX] ? pinCtrlOut[p] :
          pinUserSignal[p];
      end
    end
  endgenerate

  // ----------------------------------------
  // quadrant fan-out
  // ----------------------------------------
  // words per quadrant: rows, blocks, I/O low half, I/O high half
  genvar q;
  generate
    for (q = 0; q < `CCSG_N_QUAD; q = q + 1) begin : gQuad
      wire [31:0] w0 = cfg[IQ + 4 * q];
      wire [31:0] w1 = cfg[IQ + 4 * q + 1];
      wire [31:0] w2 = cfg[IQ + 4 * q + 2];
      wire [31:0] w3 = cfg[IQ + 4 * q + 3];
      ccsg_quad_fanout uFan (
        .clock(clock),
        .rst_n(rst_n),
        .resources({regionalClockNet[q*`CCSG_N_RPQ +: `CCSG_N_RPQ],
          globalClockNet}),
        .rowSel(w0[`CCSG_N_ROW*`CCSG_RES_SEL_W-1:0]),
        .labSel(w1[`CCSG_N_LAB*`CCSG_ROW_SEL_W-1:0]),
        .ioSel({w3[`CCSG_IO_HALF-1:0], w2[`CCSG_IO_HALF-1:0]}),
        .rowClock(rowClock[q*`CCSG_N_ROW +: `CCSG_N_ROW]),
        .labClock(labClock[q*`CCSG_N_LAB +: `CCSG_N_LAB]),
        .ioClock(ioClock[q*`CCSG_N_IO +: `CCSG_N_IO])
      );
    end
  endgenerate

  // runt pulses on switching are not filtered here; fabric must cope.
endmodule

/* ccsg_clock_net_asserts.sv */
// port checks for the clock network select and gate block
`timescale 1ns/1ps
module ccsg_clock_net_asserts #(
  parameter NPIN = 8
) (
  input wire clock, // clock
  input wire rst_n, // reset, low
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [11:0] wb_adr_i, // byte address
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire [NPIN-1:0] pinUserSignal, // pin data
  input wire [15:0] globalClockNet, // globals
  input wire [31:0] regionalClockNet, // regionals
  input wire [NPIN-1:0] pllOutPin, // pins
  input wire [23:0] rowClock, // rows
  input wire [11:0] labClock, // blocks
  input wire [31:0] ioClock // io
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // conservative: any write request ends the all-off window
  reg wrote;
  reg pinWrote;
  always @(posedge clock) begin
    if (!rst_n) begin
      wrote <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i) begin
      wrote <= 1'b1;
    end
  end
  // pin words sit in the 0x2xx window; until one is written the pins carry user data
  always @(posedge clock) begin
    if (!rst_n) begin
      pinWrote <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[11:8] == 4'h2) begin
      pinWrote <= 1'b1;
    end
  end
  sequence sTake;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sAnswer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_NEXT: assert property (sTake |=> sAnswer)
    else $error("request without single ack");
  AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  AST_RESET_OFF: assert property (
    $rose(rst_n) |-> globalClockNet == 16'h0000 && regionalClockNet == 32'h0)
    else $error("net active right after reset");
  AST_UNUSED_OFF: assert property (
    !wrote |-> globalClockNet == 16'h0000 && regionalClockNet == 32'h0
      && rowClock == 24'h0 && labClock == 12'h000 && ioClock == 32'h0)
    else $error("unconfigured net not off");
  AST_PIN_USER: assert property (
    !pinWrote && $past(rst_n) |-> pllOutPin == $past(pinUserSignal))
    else $error("pin not carrying user signal");
  AST_ROW_SRC: assert property (
    rowClock[5:0] != 6'h00 |-> $past(globalClockNet) != 16'h0000
      || $past(regionalClockNet[7:0]) != 8'h00)
    else $error("row clock without quadrant source");
  AST_LAB_ROW: assert property (
    labClock[2:0] != 3'h0 |-> $past(rowClock[5:0]) != 6'h00)
    else $error("block clock without row clock");
  AST_IO_SRC: assert property (
    ioClock[7:0] != 8'h00 |-> $past(globalClockNet) != 16'h0000
      || $past(regionalClockNet[7:0]) != 8'h00)
    else $error("io clock without quadrant source");
endmodule
bind ccsg_clock_net ccsg_clock_net_asserts #(.NPIN(NPIN)) u_chk (.*);

/* ccsg_consts.vh */
// constants shared by the clock network select and gate block
`ifndef CCSG_CONSTS_VH
`define CCSG_CONSTS_VH
// source vector layout (select index)
`define CCSG_SEL_W 6
`define CCSG_NSRC 49
`define CCSG_SRC_COMPL 6'h10
`define CCSG_SRC_FAST 6'h20
`define CCSG_SRC_ENH 6'h28
`define CCSG_SRC_CORNER 6'h2c
`define CCSG_SRC_INTERNAL 6'h30
// true pin sides: left 0-3, right 4-7, top 8-11, bottom 12-15
`define CCSG_PIN_TB 6'h08
// complement pins that may reach regional selects (top and bottom)
`define CCSG_COMPL_TB_MASK 16'hff00
// dynamic select codes
`define CCSG_DSEL_A 2'h0
`define CCSG_DSEL_B 2'h1
// configuration word fields
`define CCSG_F_SEL 0
`define CCSG_F_ALT 8
`define CCSG_F_DYN 16
`define CCSG_F_EN 17
`define CCSG_F_DUAL 18
`define CCSG_F_VERT 19
`define CCSG_F_PINMUX 20
`define CCSG_CFG_RST 32'h00000000
// byte offsets
`define CCSG_OFS_GLOBAL 12'h000
`define CCSG_OFS_REGION 12'h100
`define CCSG_OFS_PIN 12'h200
`define CCSG_OFS_QUAD 12'h300
`define CCSG_OFS_ST_GLOBAL 12'h400
`define CCSG_OFS_ST_REGION 12'h404
`define CCSG_OFS_ST_CHOICE 12'h408
`define CCSG_OFS_ST_PIN 12'h40c
// quadrant geometry
`define CCSG_N_QUAD 4
`define CCSG_N_GLOBAL 16
`define CCSG_N_RPQ 8
`define CCSG_N_RES 24
`define CCSG_N_ROW 6
`define CCSG_N_LAB 3
`define CCSG_N_IO 8
`define CCSG_RES_SEL_W 5
`define CCSG_ROW_SEL_W 3
`define CCSG_IO_HALF 20
`endif

/* ccsg_ctrl_block.v */
// one clock control block: source select and synchronous power-down
`timescale 1ns/1ps
`include "ccsg_consts.vh"
module ccsg_ctrl_block #(
  parameter DYN = 1,
  parameter NSRC = `CCSG_NSRC
) (
  input wire clock, // system clock
  input wire rst_n, // sync reset, low
  input wire [NSRC-1:0] srcVec, // candidate sources
  input wire [`CCSG_SEL_W-1:0] staticSel, // configured source / candidate A
  input wire [`CCSG_SEL_W-1:0] altSel, // candidate B
  input wire dynMode, // dynamic selection requested
  input wire [1:0] dynSel, // user select code
  input wire userMode, // device in user mode
  input wire staticEn, // configured power-up
  input wire dynEn, // user clock enable
  output reg netOut, // gated net
  output reg netActive, // enable state
  output reg choiceB // candidate B in use
);
  // ----------------------------------------
  // selection
  // ----------------------------------------
  function dynCapable;
    input [`CCSG_SEL_W-1:0] s;
    begin
      dynCapable = (s < `CCSG_SRC_COMPL) ||
        (s >= `CCSG_SRC_FAST && s < `CCSG_SRC_CORNER);
    end
  endfunction

  wire dynOn = (DYN != 0) && dynMode && userMode &&
    dynCapable(staticSel) && dynCapable(altSel);
  wire [`CCSG_SEL_W-1:0] sel = (dynOn && choiceB) ? altSel : staticSel;
  wire rawClk = (sel < NSRC) ? srcVec[sel] : 1'b0;

  always @(posedge clock) begin
    if (!rst_n) begin
      choiceB <= 1'b0;
    end else if (!dynOn) begin
      choiceB <= 1'b0;
    end else if (dynSel == `CCSG_DSEL_A) begin
      choiceB <= 1'b0;
    end else if (dynSel == `CCSG_DSEL_B) begin
      choiceB <= 1'b1;
    end
  end

  // ----------------------------------------
  // gating
  // ----------------------------------------
  // enable moves only while the source is low: no clipped high pulse
  always @(posedge clock) begin
    if (!rst_n) begin
      netActive <= 1'b0;
      netOut <= 1'b0;
    end else begin
      if (!rawClk) begin
        netActive <= staticEn & dynEn;
      end
      netOut <= rawClk & netActive;
    end
  end
endmodule

/* ccsg_fabric_model.sv */
// user fabric and candidate clock sources facing the clock network block
`timescale 1ns/1ps
module ccsg_fabric_model (
  input wire clock, // system clock
  input wire rst_n, // reset, low
  input wire [1:0] cmdSel, // wanted select code
  input wire cmdEn, // wanted enable
  input wire cmdUser, // wanted user mode
  output logic [15:0] trueClockInput, // pins
  output logic [15:0] complementClockInput, // inverted pins
  output logic [7:0] fastPllClock, // fast PLL
  output logic [3:0] enhancedPllClock, // enhanced PLL
  output logic [3:0] cornerPllClock, // corner PLL
  output logic [15:0] internalGlobalDrive, // fabric drive
  output logic [31:0] internalRegionalDrive, // fabric drive
  output logic userMode, // user mode
  output logic [31:0] globalDynSelect, // select codes
  output logic [15:0] globalDynEnable, // enables
  output logic [31:0] regionalDynEnable, // enables
  output logic [7:0] pinDynEnable // enables
);
  logic [1:0] ph = 2'h0;
  logic [1:0] sel = 2'h0;
  logic en = 1'b0;
  logic um = 1'b0;
  // fabric acts only on its own clock, so runts on gated nets never reach it
  always @(posedge clock) begin
    ph <= rst_n ? ph + 2'h1 : 2'h0;
    sel <= cmdSel;
    en <= cmdEn;
    um <= cmdUser;
  end
  // even pins toggle every cycle, odd pins every second cycle
  always_comb begin
    trueClockInput = {8{ph}};
    complementClockInput = ~{8{ph}};
    fastPllClock = {4{ph}};
    enhancedPllClock = {2{ph}};
    cornerPllClock = {2{ph}};
    internalGlobalDrive = {16{ph[0]}};
    internalRegionalDrive = {32{ph[1]}};
    userMode = um;
    globalDynSelect = {16{sel}};
    globalDynEnable = {16{en}};
    regionalDynEnable = {32{en}};
    pinDynEnable = {8{en}};
  end
endmodule

/* ccsg_quad_fanout.v */
// per-quadrant fan-out: row clocks, block clocks, I/O region clocks
`timescale 1ns/1ps
`include "ccsg_consts.vh"
module ccsg_quad_fanout (
  input wire clock, // system clock
  input wire rst_n, // sync reset, low
  input wire [`CCSG_N_RES-1:0] resources, // 16 global + 8 regional
  input wire [`CCSG_N_ROW*`CCSG_RES_SEL_W-1:0] rowSel, // row picks
  input wire [`CCSG_N_LAB*`CCSG_ROW_SEL_W-1:0] labSel, // block picks
  input wire [`CCSG_N_IO*`CCSG_RES_SEL_W-1:0] ioSel, // I/O picks
  output reg [`CCSG_N_ROW-1:0] rowClock, // row clocks
  output reg [`CCSG_N_LAB-1:0] labClock, // block register clocks
  output reg [`CCSG_N_IO-1:0] ioClock // I/O region clocks
);
  genvar k;
  generate
    for (k = 0; k < `CCSG_N_ROW; k = k + 1) begin : gRow
      wire [`CCSG_RES_SEL_W-1:0] s = rowSel[k*`CCSG_RES_SEL_W +: `CCSG_RES_SEL_W];
      always @(posedge clock) begin
        if (!rst_n) rowClock[k] <= 1'b0;
        else rowClock[k] <= (s < `CCSG_N_RES) ? resources[s] : 1'b0;
      end
    end
    for (k = 0; k < `CCSG_N_LAB; k = k + 1) begin : gLab
      wire [`CCSG_ROW_SEL_W-1:0] s = labSel[k*`CCSG_ROW_SEL_W +: `CCSG_ROW_SEL_W];
      always @(posedge clock) begin
        if (!rst_n) labClock[k] <= 1'b0;
        else labClock[k] <= (s < `CCSG_N_ROW) ? rowClock[s] : 1'b0;
      end
    end
    for (k = 0; k < `CCSG_N_IO; k = k + 1) begin : gIo
      wire [`CCSG_RES_SEL_W-1:0] s = ioSel[k*`CCSG_RES_SEL_W +: `CCSG_RES_SEL_W];
      always @(posedge clock) begin
        if (!rst_n) ioClock[k] <= 1'b0;
        else ioClock[k] <= (s < `CCSG_N_RES) ? resources[s] : 1'b0;
      end
    end
  endgenerate
endmodule

/* test_ccsg_clock_net.sv */
// self-checking bench for the clock network select and gate block
`timescale 1ns/1ps
module test_ccsg_clock_net;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, userMode, cmdEn, cmdUser;
  logic [11:0] wb_adr_i, labClock;
  logic [3:0] wb_sel_i, enhancedPllClock, cornerPllClock;
  logic [31:0] wb_dat_i, wb_dat_o, internalRegionalDrive, globalDynSelect;
  logic [31:0] regionalDynEnable, regionalClockNet, ioClock, rd;
  logic [15:0] trueClockInput, complementClockInput, internalGlobalDrive;
  logic [15:0] globalDynEnable, globalClockNet;
  logic [7:0] fastPllClock, pinDynEnable, pinUserSignal, pllOutPin;
  logic [23:0] rowClock;
  logic [1:0] cmdSel;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int regModel [int];
  logic [11:0] rstAdr [7] = '{12'h000, 12'h100, 12'h200, 12'h400, 12'h404, 12'h408, 12'h40c};
  int bSel [7] = '{1, 1, 1, 1, 1, 44, 16};
  int code [7] = '{1, 2, 0, 3, 1, 1, 1};
  int um [7] = '{1, 1, 1, 1, 0, 1, 1};
  int expB [7] = '{1, 1, 0, 0, 0, 0, 0};
  ccsg_clock_net dut (.*);
  ccsg_fabric_model fabric (.*);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkNet(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t net %b expected %b", $time, got, exp);
    end
  endtask
  // model keeps only the configuration words; status words are read-only
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (w && a < 12'h400) regModel[a] = d;
  endtask
  task automatic chkRead(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chkReg(rd, exp);
  endtask
  function automatic logic [31:0] modelRd(input logic [11:0] a);
    return regModel.exists(a) ? 32'(regModel[a]) : 32'h0;
  endfunction
  task automatic settle;
    repeat (6) @(posedge clock);
  endtask
  // net 0 of kind 0 global or 1 regional against pin src one cycle back, -1 off
  task automatic follow(input int kind, input int src);
    logic prev;
    @(negedge clock);
    repeat (6) begin
      prev = src < 0 ? 1'b0 : trueClockInput[src];
      @(negedge clock);
      chkNet(kind == 0 ? globalClockNet[0] : regionalClockNet[0], prev);
    end
  endtask
  // row 1 and I/O 0 one edge behind regional net 0, block 0 one edge behind row 1
  task automatic fan;
    logic pn, pr;
    @(negedge clock);
    repeat (6) begin
      pn = regionalClockNet[0];
      pr = rowClock[1];
      @(negedge clock);
      chkNet(rowClock[1], pn);
      chkNet(ioClock[0], pn);
      chkNet(labClock[0], pr);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(12240));
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, cmdEn, cmdUser} = 6'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    cmdSel = 2'h0;
    pinUserSignal = 8'h00;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rstAdr[k]) chkRead(rstAdr[k], 32'h0);
    follow(0, -1);
    bus(12'h7f0, 1'b1, $urandom());
    chkRead(12'h7f0, 32'h0);
    bus(12'h400, 1'b1, 32'hffff);
    chkRead(12'h400, 32'h0);
    cmdEn <= 1'b1;
    bus(12'h000, 1'b1, 32'h20000);
    settle;
    follow(0, 0);
    chkRead(12'h400, 32'h1);
    bus(12'h000, 1'b1, 32'h20001);
    settle;
    follow(0, 1);
    cmdEn <= 1'b0;
    settle;
    follow(0, -1);
    chkRead(12'h400, 32'h0);
    cmdEn <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      bus(12'h000, 1'b1, 32'h30000 | (bSel[k] << 8));
      cmdSel <= code[k][1:0];
      cmdUser <= um[k][0];
      settle;
      follow(0, expB[k]);
      chkRead(12'h408, 32'(expB[k]));
    end
    bus(12'h000, 1'b1, 32'h20100);
    settle;
    follow(0, 0);
    // dynamic bit on a regional word must not let code 1 pick pin 0
    bus(12'h100, 1'b1, 32'h30001);
    settle;
    follow(1, 1);
    chkRead(12'h404, 32'h1);
    chkRead(12'h100, modelRd(12'h100));
    // quadrant 0: row 1 and I/O 0 take resource 16 (regional line 0), block 0 takes row 1
    bus(12'h300, 1'b1, 32'h200);
    bus(12'h304, 1'b1, 32'h1);
    bus(12'h308, 1'b1, 32'h10);
    settle;
    fan;
    chkRead(12'h304, modelRd(12'h304));
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      pinUserSignal <= 8'($urandom());
      repeat (3) @(posedge clock);
      chkReg(32'(pllOutPin), 32'(pinUserSignal));
    end
    pinUserSignal <= 8'hff;
    bus(12'h200, 1'b1, 32'h100000);
    settle;
    chkReg(32'(pllOutPin), 32'hfe);
    chkRead(12'h200, modelRd(12'h200));
    report_and_stop();
  end
endmodule
